// file: led_sink_cmp_pkg.sv
// constants for the sink current and light comparator register bank
// assumes a 10 MHz ref_clk and an i2c-style two-wire host link
package led_sink_cmp_pkg;

  // ****************************************
  // clock and timing
  // ****************************************
  localparam int CLK_HZ = 10_000_000;
  localparam int FILTER_BASE_MS = 80;
  localparam int FILTER_BASE_CYCLES = FILTER_BASE_MS * (CLK_HZ / 1000);
  localparam int CONV_CYCLES = 4;
  localparam int FILTER_CNT_W = 27;

  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [7:0] OFF_SINK_TWO_CURRENT = 8'h19;
  localparam logic [7:0] OFF_SINK_ONE_CURRENT = 8'h1A;
  localparam logic [7:0] OFF_LIGHT_CMP_CONFIG = 8'h1B;

  // ****************************************
  // field positions
  // ****************************************
  localparam int SINK_CODE_MSB = 6;
  localparam int SINK_RSVD_BIT = 7;
  localparam int SETTLE_MSB = 7;
  localparam int SETTLE_LSB = 5;
  localparam int FORCE_READ_BIT = 4;
  localparam int DARK_TRIP_BIT = 3;
  localparam int OFFICE_TRIP_BIT = 2;
  localparam int DARK_ON_BIT = 1;
  localparam int OFFICE_ON_BIT = 0;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [6:0] SINK_CODE_RESET = 7'h00;
  localparam logic [2:0] SETTLE_RESET = 3'h0;
  localparam logic [7:0] LINK_IDLE_BYTE = 8'hFF;

  // device address on the link; value is arbitrary
  localparam logic [6:0] DEVICE_ADDR = 7'h2A;

  // ****************************************
  // lighting levels
  // ****************************************
  localparam logic [1:0] LEVEL_NORMAL = 2'h0;
  localparam logic [1:0] LEVEL_OFFICE = 2'h2;
  localparam logic [1:0] LEVEL_DARK = 2'h3;

  typedef enum logic [3:0] {
    LINK_IDLE, LINK_ADDR, LINK_ADDR_ACK, LINK_PTR, LINK_PTR_ACK,
    LINK_WR, LINK_WR_ACK, LINK_RD, LINK_RD_ACK
  } link_state_type;

endpackage

// file: led_sink_and_light_comparator_regs.sv
// sink current codes and primary light comparator configuration
// assumes scl/sda arrive synchronous to ref_clk, open-drain sda outside
// Contract
// - sink two holds 7-bit code, bit7 reserved
// - sink one holds 7-bit code, bit7 reserved
// - codes drive the current dac unchanged
// - bits 7:5 pick filter period 80ms doubling
// - bit4 write forces one conversion
// - force bit self-clears after conversion completes
// - force request ignored while backlight enabled
// - bit3 shows dark-level comparator output
// - bit2 shows office-level comparator output
// - bit1 enables dark-level comparator
// - bit0 enables office-level comparator
// - dark level wins over office level
// - below office threshold selects office mode
module led_sink_and_light_comparator_regs #(
  parameter int FILTER_BASE_CYCLES = led_sink_cmp_pkg::FILTER_BASE_CYCLES
) (
  input wire logic ref_clk, // 10 MHz clock
  input wire logic reset_n, // async reset, active low
  input wire logic scl, // link clock from host
  input wire logic sdaIn, // link data level
  output logic sdaOut, // link data value, always low
  output logic sdaOeN, // low while pulling sda low
  input wire logic darkBelow, // sensor below dark threshold
  input wire logic officeBelow, // sensor below office threshold
  input wire logic sinksActive, // independent sinks running
  input wire logic backlightOn, // backlight enabled
  output logic [6:0] sinkOneCode, // current code, sink one
  output logic [6:0] sinkTwoCode, // current code, sink two
  output logic [1:0] backlightLevel, // chosen lighting level
  output logic convBusy // sensor conversion running
);

  // ****************************************
  // register read mux
  // ****************************************
  function automatic logic [7:0] regRead(input logic [7:0] ptr,
    input logic [6:0] one, input logic [6:0] two, input logic [7:0] cfg);
    logic [7:0] r;
    r = 8'h00;
    case (ptr)
      led_sink_cmp_pkg::OFF_SINK_TWO_CURRENT: r = {1'b0, two};
      led_sink_cmp_pkg::OFF_SINK_ONE_CURRENT: r = {1'b0, one};
      led_sink_cmp_pkg::OFF_LIGHT_CMP_CONFIG: r = cfg;
      default: r = 8'h00;
    endcase
    return r;
  endfunction

  led_sink_cmp_pkg::link_state_type state_reg;
  logic sclPrev_reg, sdaPrev_reg, converting_reg, sdaOeN_reg;
  logic [3:0] bitCnt_reg;
  logic [7:0] shift_reg, ptr_reg;
  logic [6:0] sinkOne_reg, sinkTwo_reg;
  logic [2:0] settle_reg, convCnt_reg;
  logic force_reg, darkOn_reg, officeOn_reg, darkTrip_reg, officeTrip_reg;
  logic [led_sink_cmp_pkg::FILTER_CNT_W-1:0] filterCnt_reg;

  // ****************************************
  // link edge and condition decode
  // ****************************************
  wire sclRise = scl & ~sclPrev_reg;
  wire sclFall = ~scl & sclPrev_reg;
  wire startSeen = scl & sclPrev_reg & sdaPrev_reg & ~sdaIn;
  wire stopSeen = scl & sclPrev_reg & ~sdaPrev_reg & sdaIn;
  wire byteFull = bitCnt_reg == 4'h8;
  wire addrMatch = shift_reg[7:1] == led_sink_cmp_pkg::DEVICE_ADDR;
  wire [7:0] cfgView = {settle_reg, force_reg, darkTrip_reg,
    officeTrip_reg, darkOn_reg, officeOn_reg};
  wire [7:0] readByte = regRead(ptr_reg, sinkOne_reg, sinkTwo_reg, cfgView);
  wire wrStrobe = sclFall && byteFull && state_reg == led_sink_cmp_pkg::LINK_WR;
  wire wrSinkTwo = wrStrobe &&
    ptr_reg == led_sink_cmp_pkg::OFF_SINK_TWO_CURRENT;
  wire wrSinkOne = wrStrobe &&
    ptr_reg == led_sink_cmp_pkg::OFF_SINK_ONE_CURRENT;
  wire wrCfg = wrStrobe && ptr_reg == led_sink_cmp_pkg::OFF_LIGHT_CMP_CONFIG;
  // a request made while the backlight runs never reaches the flop
  wire forceSet = wrCfg && shift_reg[led_sink_cmp_pkg::FORCE_READ_BIT] &&
    !backlightOn;

  // ****************************************
  // two-wire link slave
  // ****************************************
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sclPrev_reg <= 1'b1;
      sdaPrev_reg <= 1'b1;
    end else begin
      sclPrev_reg <= scl;
      sdaPrev_reg <= sdaIn;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= led_sink_cmp_pkg::LINK_IDLE;
      bitCnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      ptr_reg <= 8'h00;
      sdaOeN_reg <= 1'b1;
    end else if (startSeen) begin
      state_reg <= led_sink_cmp_pkg::LINK_ADDR;
      bitCnt_reg <= 4'h0;
      sdaOeN_reg <= 1'b1;
    end else if (stopSeen) begin
      state_reg <= led_sink_cmp_pkg::LINK_IDLE;
      sdaOeN_reg <= 1'b1;
    end else begin
      case (state_reg)
        led_sink_cmp_pkg::LINK_ADDR, led_sink_cmp_pkg::LINK_PTR,
        led_sink_cmp_pkg::LINK_WR: begin
          if (sclRise && !byteFull) begin
            shift_reg <= {shift_reg[6:0], sdaIn};
            bitCnt_reg <= bitCnt_reg + 4'h1;
          end else if (sclFall && byteFull) begin
            bitCnt_reg <= 4'h0;
            if (state_reg == led_sink_cmp_pkg::LINK_ADDR) begin
              if (addrMatch) begin
                sdaOeN_reg <= 1'b0;
                state_reg <= led_sink_cmp_pkg::LINK_ADDR_ACK;
              end else begin
                state_reg <= led_sink_cmp_pkg::LINK_IDLE;
              end
            end else if (state_reg == led_sink_cmp_pkg::LINK_PTR) begin
              ptr_reg <= shift_reg;
              sdaOeN_reg <= 1'b0;
              state_reg <= led_sink_cmp_pkg::LINK_PTR_ACK;
            end else begin
              ptr_reg <= ptr_reg + 8'h01;
              sdaOeN_reg <= 1'b0;
              state_reg <= led_sink_cmp_pkg::LINK_WR_ACK;
            end
          end
        end
        led_sink_cmp_pkg::LINK_ADDR_ACK: begin
          if (sclFall) begin
            if (shift_reg[0]) begin
              shift_reg <= readByte;
              sdaOeN_reg <= readByte[7];
              bitCnt_reg <= 4'h1;
              state_reg <= led_sink_cmp_pkg::LINK_RD;
            end else begin
              sdaOeN_reg <= 1'b1;
              state_reg <= led_sink_cmp_pkg::LINK_PTR;
            end
          end
        end
        led_sink_cmp_pkg::LINK_PTR_ACK, led_sink_cmp_pkg::LINK_WR_ACK: begin
          if (sclFall) begin
            sdaOeN_reg <= 1'b1;
            state_reg <= led_sink_cmp_pkg::LINK_WR;
          end
        end
        led_sink_cmp_pkg::LINK_RD: begin
          if (sclFall) begin
            if (byteFull) begin
              sdaOeN_reg <= 1'b1;
              ptr_reg <= ptr_reg + 8'h01;
              state_reg <= led_sink_cmp_pkg::LINK_RD_ACK;
            end else begin
              shift_reg <= {shift_reg[6:0], 1'b0};
              sdaOeN_reg <= shift_reg[6];
              bitCnt_reg <= bitCnt_reg + 4'h1;
            end
          end
        end
        led_sink_cmp_pkg::LINK_RD_ACK: begin
          // a high ack bit from the host ends the read burst
          if (sclRise && sdaIn) begin
            state_reg <= led_sink_cmp_pkg::LINK_IDLE;
          end else if (sclFall) begin
            shift_reg <= readByte;
            sdaOeN_reg <= readByte[7];
            bitCnt_reg <= 4'h1;
            state_reg <= led_sink_cmp_pkg::LINK_RD;
          end
        end
        default: sdaOeN_reg <= 1'b1;
      endcase
    end
  end

  // ****************************************
  // sink and comparator registers
  // ****************************************
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sinkOne_reg <= led_sink_cmp_pkg::SINK_CODE_RESET;
      sinkTwo_reg <= led_sink_cmp_pkg::SINK_CODE_RESET;
      settle_reg <= led_sink_cmp_pkg::SETTLE_RESET;
      darkOn_reg <= 1'b0;
      officeOn_reg <= 1'b0;
    end else begin
      if (wrSinkOne) begin
        sinkOne_reg <= shift_reg[led_sink_cmp_pkg::SINK_CODE_MSB:0];
      end
      if (wrSinkTwo) begin
        sinkTwo_reg <= shift_reg[led_sink_cmp_pkg::SINK_CODE_MSB:0];
      end
      if (wrCfg) begin
        settle_reg <= shift_reg[led_sink_cmp_pkg::SETTLE_MSB:
          led_sink_cmp_pkg::SETTLE_LSB];
        darkOn_reg <= shift_reg[led_sink_cmp_pkg::DARK_ON_BIT];
        officeOn_reg <= shift_reg[led_sink_cmp_pkg::OFFICE_ON_BIT];
      end
    end
  end

  // ****************************************
  // filter timer and conversion
  // ****************************************
  wire [led_sink_cmp_pkg::FILTER_CNT_W-1:0] periodLast =
    led_sink_cmp_pkg::FILTER_CNT_W'((FILTER_BASE_CYCLES << settle_reg) - 1);
  wire timerDue = backlightOn && filterCnt_reg >= periodLast;
  wire forceGo = force_reg && sinksActive && !backlightOn;
  wire convStart = !converting_reg && (timerDue || forceGo);
  wire convDone = converting_reg &&
    convCnt_reg == 3'(led_sink_cmp_pkg::CONV_CYCLES - 1);
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      filterCnt_reg <= '0;
    end else if (!backlightOn || timerDue) begin
      filterCnt_reg <= '0;
    end else begin
      filterCnt_reg <= filterCnt_reg + 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      converting_reg <= 1'b0;
      convCnt_reg <= 3'h0;
      force_reg <= 1'b0;
      darkTrip_reg <= 1'b0;
      officeTrip_reg <= 1'b0;
      backlightLevel <= led_sink_cmp_pkg::LEVEL_NORMAL;
    end else begin
      if (convStart) begin
        converting_reg <= 1'b1;
        convCnt_reg <= 3'h0;
      end else if (convDone) begin
        converting_reg <= 1'b0;
      end else if (converting_reg) begin
        convCnt_reg <= convCnt_reg + 3'h1;
      end
      // a fresh host request in the completing cycle is kept
      if (forceSet) begin
        force_reg <= 1'b1;
      end else if (convDone) begin
        force_reg <= 1'b0;
      end
      // host writes never touch the trip flags
      if (convDone) begin
        darkTrip_reg <= darkOn_reg && darkBelow;
        officeTrip_reg <= officeOn_reg && officeBelow;
        if (darkOn_reg && darkBelow) begin
          backlightLevel <= led_sink_cmp_pkg::LEVEL_DARK;
        end else if (officeOn_reg && officeBelow) begin
          backlightLevel <= led_sink_cmp_pkg::LEVEL_OFFICE;
        end else begin
          backlightLevel <= led_sink_cmp_pkg::LEVEL_NORMAL;
        end
      end
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sinkOneCode <= led_sink_cmp_pkg::SINK_CODE_RESET;
      sinkTwoCode <= led_sink_cmp_pkg::SINK_CODE_RESET;
      sdaOut <= 1'b0;
      sdaOeN <= 1'b1;
      convBusy <= 1'b0;
    end else begin
      sinkOneCode <= sinkOne_reg;
      sinkTwoCode <= sinkTwo_reg;
      sdaOut <= 1'b0;
      sdaOeN <= sdaOeN_reg;
      convBusy <= converting_reg;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  localparam int CONV_LEN = led_sink_cmp_pkg::CONV_CYCLES;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  chk_sink_two_load: assert property (wrSinkTwo |-> ##2
    sinkTwoCode == $past(shift_reg[6:0], 2))
    else $error("sink two code not loaded");
  chk_sink_one_load: assert property (wrSinkOne |-> ##2
    sinkOneCode == $past(shift_reg[6:0], 2))
    else $error("sink one code not loaded");
  chk_rsvd_read_zero: assert property (
    (ptr_reg == led_sink_cmp_pkg::OFF_SINK_ONE_CURRENT ||
     ptr_reg == led_sink_cmp_pkg::OFF_SINK_TWO_CURRENT) |-> !readByte[7])
    else $error("reserved sink bit reads one");
  chk_timer_period: assert property (filterCnt_reg <= periodLast ||
    $changed(settle_reg))
    else $error("filter timer overran its period");
  chk_force_starts: assert property (forceGo && !converting_reg
    |=> converting_reg ##CONV_LEN !converting_reg)
    else $error("forced read did not run one conversion");
  chk_force_clears: assert property (convDone && !forceSet
    |=> !force_reg)
    else $error("force bit not cleared after conversion");
  chk_force_ignored: assert property (wrCfg && backlightOn &&
    !force_reg |=> !force_reg)
    else $error("force accepted while backlight on");
  chk_dark_result: assert property (convDone |=>
    darkTrip_reg == ($past(darkOn_reg) && $past(darkBelow)))
    else $error("dark flag wrong after conversion");
  chk_office_off: assert property (convDone && !officeOn_reg
    |=> !officeTrip_reg)
    else $error("office flag set while disabled");
  chk_dark_priority: assert property (darkTrip_reg |->
    backlightLevel == led_sink_cmp_pkg::LEVEL_DARK)
    else $error("dark level lost priority");
  chk_office_mode: assert property (officeTrip_reg && !darkTrip_reg
    |-> backlightLevel == led_sink_cmp_pkg::LEVEL_OFFICE)
    else $error("office mode not selected");
  chk_flags_readonly: assert property (wrCfg && !convDone
    |=> $stable(darkTrip_reg) && $stable(officeTrip_reg))
    else $error("host write changed a trip flag");
  cov_forced_read: cover property (forceSet ##[1:20] convDone);
  cov_timer_read: cover property (timerDue && !converting_reg);
  cov_both_trip: cover property (darkTrip_reg && officeTrip_reg);
  cov_read_burst: cover property (
    state_reg == led_sink_cmp_pkg::LINK_RD_ACK && sclFall);
endmodule // led_sink_and_light_comparator_regs

// file: light_host_model.sv
// host-side two-wire master for the sink and comparator register bank
// assumes the bench resolves the open-drain sda wire with a pull-up
module light_host_model #(
  parameter int HALF = 4 // ref_clk cycles per scl phase
) (
  input wire logic refClk, // bench clock
  input wire logic sdaLine, // resolved sda level
  output logic scl, // link clock to the device
  output logic sdaDrive // 0 pulls sda low, 1 releases
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    scl = 1'b1;
    sdaDrive = 1'b1;
  end

  task automatic waitN(input int n);
    repeat (n) @(negedge refClk);
  endtask

  // ****************************************
  // bit level
  // ****************************************
  // sda never moves in the step where scl falls, so no false stop
  task automatic startBit();
    waitN(1);
    sdaDrive = 1'b1;
    waitN(HALF);
    scl = 1'b1;
    waitN(HALF);
    sdaDrive = 1'b0;
    waitN(HALF);
    scl = 1'b0;
  endtask

  task automatic stopBit();
    waitN(1);
    sdaDrive = 1'b0;
    waitN(HALF);
    scl = 1'b1;
    waitN(HALF);
    sdaDrive = 1'b1;
    waitN(HALF);
  endtask

  task automatic putBit(input logic b);
    waitN(1);
    sdaDrive = b;
    waitN(HALF - 1);
    scl = 1'b1;
    waitN(HALF);
    scl = 1'b0;
  endtask

  // sampled late in the high phase, after the device has settled
  task automatic getBit(output logic b);
    waitN(1);
    sdaDrive = 1'b1;
    waitN(HALF - 1);
    scl = 1'b1;
    waitN(HALF);
    b = sdaLine;
    scl = 1'b0;
  endtask

  // ****************************************
  // byte and transfer level
  // ****************************************
  task automatic sendByte(input logic [7:0] d, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) putBit(d[i]);
    getBit(b);
    ack = (b === 1'b0);
  endtask

  task automatic recvByte(output logic [7:0] d, input logic last);
    for (int i = 7; i >= 0; i--) getBit(d[i]);
    putBit(last);
  endtask

  task automatic writeReg(input logic [6:0] dev, input logic [7:0] ptr,
                          input logic [7:0] d, output logic ok);
    logic a, b, c;
    startBit();
    sendByte({dev, 1'b0}, a);
    sendByte(ptr, b);
    sendByte(d, c);
    stopBit();
    ok = a & b & c;
  endtask

  task automatic readReg(input logic [6:0] dev, input logic [7:0] ptr,
                         output logic [7:0] d, output logic ok);
    logic a, b, c;
    startBit();
    sendByte({dev, 1'b0}, a);
    sendByte(ptr, b);
    startBit();
    sendByte({dev, 1'b1}, c);
    recvByte(d, 1'b1);
    stopBit();
    ok = a & b & c;
  endtask
endmodule // light_host_model

// file: led_sink_and_light_comparator_regs_tb.sv
// self-checking bench for the sink and comparator register bank
// assumes the host model owns the link and the bench the sensor inputs
module led_sink_and_light_comparator_regs_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int BASE = 8;
  localparam int CEILING = 60000;
  localparam logic [6:0] DEV = led_sink_cmp_pkg::DEVICE_ADDR;
  logic refClk = 1'b0;
  logic resetN = 1'b0;
  logic darkBelow = 1'b0;
  logic officeBelow = 1'b0;
  logic sinksActive = 1'b0;
  logic backlightOn = 1'b0;
  logic scl, sdaDrive, sdaOut, sdaOeN, convBusy;
  logic [6:0] sinkOneCode, sinkTwoCode;
  logic [1:0] backlightLevel;
  wire logic sdaLine = sdaDrive & (sdaOeN | sdaOut);
  int errors = 0;
  int compares = 0;
  int cycles = 0;
  int model [3];
  logic [31:0] seed = 32'h0000_0B4D;

  always #50 refClk = ~refClk;

  led_sink_and_light_comparator_regs #(.FILTER_BASE_CYCLES(BASE)) u_dut (
    .ref_clk(refClk), .reset_n(resetN), .scl(scl), .sdaIn(sdaLine),
    .sdaOut(sdaOut), .sdaOeN(sdaOeN), .darkBelow(darkBelow),
    .officeBelow(officeBelow), .sinksActive(sinksActive),
    .backlightOn(backlightOn), .sinkOneCode(sinkOneCode),
    .sinkTwoCode(sinkTwoCode), .backlightLevel(backlightLevel),
    .convBusy(convBusy));

  light_host_model u_host (.refClk(refClk), .sdaLine(sdaLine), .scl(scl),
    .sdaDrive(sdaDrive));

  // ****************************************
  // reference model and helpers
  // ****************************************
  function automatic logic [31:0] nextRand();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // timed reads refresh flags while backlight runs, so force adds nothing;
  // a request made with the sinks idle stays pending until they start
  function automatic int cfgAfter(input int old, input logic [7:0] d);
    logic [1:0] f;
    logic pend;
    f = old[3:2];
    pend = !sinksActive && !backlightOn && (old[4] || d[4]);
    if (backlightOn || (d[4] && sinksActive)) begin
      f = d[1:0] & {darkBelow, officeBelow};
    end
    return {d[7:5], pend, f, d[1:0]};
  endfunction

  function automatic logic [1:0] levelOf(input logic [1:0] f);
    if (f[1]) return led_sink_cmp_pkg::LEVEL_DARK;
    if (f[0]) return led_sink_cmp_pkg::LEVEL_OFFICE;
    return led_sink_cmp_pkg::LEVEL_NORMAL;
  endfunction

  task automatic check(input logic [15:0] got, input logic [15:0] exp,
                       input string what);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] ptr, input logic [7:0] d);
    logic ok;
    u_host.writeReg(DEV, ptr, d, ok);
    check(16'(ok), 16'h0001, "write ack");
    if (ptr == 8'h1B) model[2] = cfgAfter(model[2], d);
    else model[ptr - 8'h19] = d & 8'h7F;
  endtask

  task automatic rd(input logic [7:0] ptr);
    logic ok;
    logic [7:0] d;
    u_host.readReg(DEV, ptr, d, ok);
    check(16'(ok), 16'h0001, "read ack");
    check(16'(d), 16'(model[ptr - 8'h19]), "readback");
  endtask

  task automatic outs();
    check(16'(sinkTwoCode), 16'(model[0]), "sink two code");
    check(16'(sinkOneCode), 16'(model[1]), "sink one code");
    check(16'(backlightLevel), 16'(levelOf(model[2][3:2])), "level");
  endtask

  task automatic nextRise(output int n);
    logic prev;
    for (n = 1; n < 3000; n++) begin
      prev = convBusy;
      @(negedge refClk);
      if (prev === 1'b0 && convBusy === 1'b1) break;
    end
  endtask

  task automatic summarize();
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  always @(posedge refClk) begin
    cycles++;
    if (cycles == CEILING) begin
      errors++;
      $display("[FAIL] %0t run took too long", $time);
      summarize();
    end
  end

  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    int gap;
    logic ok;
    logic [7:0] d;
    for (int k = 0; k < 3; k++) model[k] = 0;
    repeat (10) @(negedge refClk);
    resetN = 1'b1;
    repeat (2) @(negedge refClk);
    check(16'(convBusy), 16'h0000, "busy after reset");
    for (int k = 0; k < 3; k++) rd(8'h19 + 8'(k));
    outs();
    for (int k = 0; k < 6; k++) begin
      d = (k == 0) ? 8'hFF : (k == 1) ? 8'h80 : 8'(nextRand());
      wr(8'h19 + 8'(k % 2), d);
      rd(8'h19 + 8'(k % 2));
      outs();
    end
    // all settle codes; trip flag bits written high must not stick
    for (int k = 0; k < 8; k++) begin
      wr(8'h1B, {3'(k), 5'b01111});
      rd(8'h1B);
    end
    sinksActive = 1'b1;
    for (int k = 0; k < 16; k++) begin
      darkBelow = k[0];
      officeBelow = k[1];
      wr(8'h1B, {4'b0001, 2'b00, 2'(k >> 2)});
      rd(8'h1B);
      outs();
    end
    backlightOn = 1'b1;
    wr(8'h1B, 8'h13);
    rd(8'h1B);
    for (int k = 0; k < 3; k++) begin
      wr(8'h1B, {3'(k), 5'b00011});
      nextRise(gap);
      nextRise(gap);
      check(16'(gap), 16'(BASE << k), "filter period");
    end
    backlightOn = 1'b0;
    u_host.readReg(DEV, 8'h20, d, ok);
    check(16'(d), 16'h0000, "unmapped read");
    u_host.readReg(DEV ^ 7'h01, 8'h19, d, ok);
    check(16'(ok), 16'h0000, "foreign address acked");
    summarize();
  end
endmodule // led_sink_and_light_comparator_regs_tb
